/* hw/rtcsq_regs.v */
// Real-time clock register bank with trimmed time base, alarms and square-wave output
`timescale 1ns/1ps
`default_nettype none
`include "rtcsq_consts.vh"

module rtcsq_regs #(
  parameter integer READY_CYCLES = (`RTQ_READY_NS + `RTQ_CLK_NS - 1) / `RTQ_CLK_NS
)
(
  input wire sys_clk,
  input wire nrst,
  input wire periph_rst,
  input wire oscillator_input_pin,
  input wire [4:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  output reg calibration_output_pin,
  output reg clock_irq,
  output reg wakeup_req
);

  // ==========================================
  // Address decode
  function hit;
    input [4:0] a;
    input [4:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // ==========================================
  // State
  reg osc_d;
  reg osc_d2;
  reg [23:0] phase;
  reg tick4k;
  reg [2:0] div8;
  reg [31:0] seconds_count;
  reg [11:0] subsecond_count;
  reg [19:0] day_alarm_match;
  reg [31:0] interval_alarm_reload;
  reg [31:0] int_cnt;
  reg [7:0] trim;
  reg [23:0] elapsed;
  reg [31:0] oscillator_control;
  reg en;
  reg day_alarm_enable;
  reg interval_alarm_enable;
  reg rd_en;
  reg sqw_en;
  reg [1:0] sqw_sel;
  reg day_flag;
  reg int_flag;
  reg rdy;
  reg [12:0] rdy_cnt;
  reg busy;
  reg [4:0] pend_addr;
  reg [31:0] pend_data;
  reg pend_wen;
  reg day_hit_q;
  reg wr_en;
  reg ready_interrupt_enable;

  wire tick32k;
  wire [23:0] next_phase;
  wire step;
  wire ssec_wrap;
  wire [31:0] sec_inc;
  wire day_hit;
  wire int_run;
  wire apply;
  wire acc_sec;
  wire acc_ssec;
  wire acc_toda;
  wire acc_sseca;
  wire acc_ctrl;
  wire acc_trim;
  wire acc_osc;
  wire stage;
  reg next_sqw;
  reg [31:0] next_rdata;

  // ==========================================
  // Time base
  assign tick32k = osc_d & ~osc_d2;
  // Phase gains 1e6 (+trim) per 32k edge; a tick every 8e6 gives 1ppm per step
  assign next_phase = phase + `RTQ_PH_STEP + {{16{trim[7]}}, trim};

  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_d <= 1'b0;
      osc_d2 <= 1'b0;
      phase <= 24'h00_0000;
      tick4k <= 1'b0;
      div8 <= 3'h0;
    end
    else
    begin
      osc_d <= oscillator_input_pin;
      osc_d2 <= osc_d;
      tick4k <= 1'b0;
      if (tick32k)
      begin
        div8 <= div8 + 3'h1;
        if (next_phase >= `RTQ_PH_PERIOD)
        begin
          phase <= next_phase - `RTQ_PH_PERIOD;
          tick4k <= 1'b1;
        end
        else
        begin
          phase <= next_phase;
        end
      end
    end
  end

  // ==========================================
  // Write acceptance
  // Writes except to the oscillator register are staged and applied on the next 32k edge, which acts as the acknowledge
  assign acc_sec = wr & ~busy & hit(addr, `RTQ_OFF_SEC);
  assign acc_ssec = wr & ~busy & hit(addr, `RTQ_OFF_SSEC);
  assign acc_toda = wr & ~busy & hit(addr, `RTQ_OFF_TODA) & (~day_alarm_enable | ~en);
  assign acc_sseca = wr & ~busy & hit(addr, `RTQ_OFF_SSECA) & (~interval_alarm_enable | ~en);
  assign acc_ctrl = wr & ~busy & hit(addr, `RTQ_OFF_CTRL);
  assign acc_trim = wr & ~busy & hit(addr, `RTQ_OFF_TRIM) & wr_en;
  assign acc_osc = wr & hit(addr, `RTQ_OFF_OSC) & wr_en;
  assign stage = acc_sec | acc_ssec | acc_toda | acc_sseca | acc_ctrl | acc_trim;
  assign apply = busy & tick32k;

  // ==========================================
  // Counters and alarms
  assign step = tick4k & en;
  assign ssec_wrap = (subsecond_count == `RTQ_SSEC_MAX);
  assign sec_inc = seconds_count + 32'h0000_0001;
  assign day_hit = (seconds_count[19:0] == day_alarm_match);
  assign int_run = en & interval_alarm_enable;

  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      seconds_count <= `RTQ_RST_ZERO;
      subsecond_count <= 12'h000;
      day_alarm_match <= 20'h0_0000;
      interval_alarm_reload <= `RTQ_RST_ZERO;
      int_cnt <= `RTQ_RST_ZERO;
      trim <= 8'h00;
      elapsed <= 24'h00_0000;
      oscillator_control <= `RTQ_RST_OSC;
      en <= 1'b0;
      day_alarm_enable <= 1'b0;
      interval_alarm_enable <= 1'b0;
      rd_en <= 1'b0;
      sqw_en <= 1'b0;
      sqw_sel <= 2'h0;
      day_flag <= 1'b0;
      int_flag <= 1'b0;
      rdy <= 1'b0;
      rdy_cnt <= 13'h0000;
      busy <= 1'b0;
      pend_addr <= 5'h00;
      pend_data <= `RTQ_RST_ZERO;
      pend_wen <= 1'b0;
      day_hit_q <= 1'b1; // Seconds and match both reset to zero; no false alarm
    end
    else
    begin
      day_hit_q <= day_hit;
      if (acc_osc)
      begin
        oscillator_control <= wdata;
      end
      // Busy handshake
      if (stage)
      begin
        busy <= 1'b1;
        pend_addr <= addr;
        pend_data <= wdata;
        pend_wen <= wr_en;
      end
      else if (apply)
      begin
        busy <= 1'b0;
      end
      // Time counters
      if (step)
      begin
        subsecond_count <= subsecond_count + 12'h001;
        if (ssec_wrap)
        begin
          seconds_count <= sec_inc;
          if ((sec_inc[4:0] & `RTQ_ELAPSE_MASK) == 5'h00)
          begin
            elapsed <= elapsed + 24'h00_0001;
          end
        end
      end
      // Interval counter held at start value while stopped, so enabling reloads it
      if (!int_run)
      begin
        int_cnt <= interval_alarm_reload;
      end
      else if (tick4k)
      begin
        if (&int_cnt)
        begin
          int_cnt <= interval_alarm_reload;
        end
        else
        begin
          int_cnt <= int_cnt + 32'h0000_0001;
        end
      end
      // Software updates land here, after hardware counting
      if (apply)
      begin
        case (pend_addr)
          `RTQ_OFF_SEC:
          begin
            seconds_count <= pend_data;
          end
          `RTQ_OFF_SSEC:
          begin
            subsecond_count <= pend_data[11:0];
          end
          `RTQ_OFF_TODA:
          begin
            day_alarm_match <= pend_data[19:0];
          end
          `RTQ_OFF_SSECA:
          begin
            interval_alarm_reload <= pend_data;
          end
          `RTQ_OFF_TRIM:
          begin
            trim <= pend_data[7:0];
            elapsed <= pend_data[31:8];
          end
          `RTQ_OFF_CTRL:
          begin
            if (pend_wen)
            begin
              en <= pend_data[`RTQ_B_EN];
            end
            day_alarm_enable <= pend_data[`RTQ_B_TOD_IE];
            interval_alarm_enable <= pend_data[`RTQ_B_INT_IE];
            rd_en <= pend_data[`RTQ_B_RD_EN];
            sqw_en <= pend_data[`RTQ_B_SQW_EN];
            sqw_sel <= pend_data[`RTQ_B_SEL_HI:`RTQ_B_SEL_LO];
            day_flag <= pend_data[`RTQ_B_TOD_FL];
            int_flag <= pend_data[`RTQ_B_INT_FL];
            if (!pend_data[`RTQ_B_RDY])
            begin
              rdy <= 1'b0;
            end
          end
          default:
          begin
            busy <= 1'b0;
          end
        endcase
      end
      // Hardware sets come last so a coincident clear never loses an event
      if (day_hit & ~day_hit_q)
      begin
        day_flag <= 1'b1;
      end
      if (int_run & tick4k & (&int_cnt))
      begin
        int_flag <= 1'b1;
      end
      if (step)
      begin
        rdy <= 1'b1;
        rdy_cnt <= READY_CYCLES[12:0];
      end
      else if (rdy_cnt != 13'h0000)
      begin
        rdy_cnt <= rdy_cnt - 13'h0001;
        if (rdy_cnt == 13'h0001)
        begin
          rdy <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // Fields also cleared by system and peripheral reset
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_en <= 1'b0;
      ready_interrupt_enable <= 1'b0;
    end
    else if (periph_rst)
    begin
      wr_en <= 1'b0;
      ready_interrupt_enable <= 1'b0;
    end
    else if (apply && pend_addr == `RTQ_OFF_CTRL)
    begin
      wr_en <= pend_data[`RTQ_B_WR_EN];
      ready_interrupt_enable <= pend_data[`RTQ_B_READY_INTERRUPT_ENABLE];
    end
  end

  // ==========================================
  // Square-wave source
  always @*
  begin
    next_sqw = 1'b0;
    if (oscillator_control[`RTQ_B_RAW])
    begin
      next_sqw = osc_d;
    end
    else if (sqw_en)
    begin
      case (sqw_sel)
        `RTQ_SEL_1HZ:
        begin
          next_sqw = en & subsecond_count[11];
        end
        `RTQ_SEL_512HZ:
        begin
          next_sqw = en & subsecond_count[2];
        end
        `RTQ_SEL_4KHZ:
        begin
          next_sqw = div8[2];
        end
        default:
        begin
          next_sqw = 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Read mux; read data stand only in the cycle after the strobe
  always @*
  begin
    next_rdata = `RTQ_RST_ZERO;
    case (addr)
      `RTQ_OFF_SEC:
      begin
        next_rdata = seconds_count;
      end
      `RTQ_OFF_SSEC:
      begin
        next_rdata = {20'h0_0000, subsecond_count};
      end
      `RTQ_OFF_TODA:
      begin
        next_rdata = {12'h000, day_alarm_match};
      end
      `RTQ_OFF_SSECA:
      begin
        next_rdata = interval_alarm_reload;
      end
      `RTQ_OFF_CTRL:
      begin
        next_rdata = {16'h0000, wr_en, rd_en, 3'h0, sqw_sel, sqw_en, int_flag, day_flag,
                      ready_interrupt_enable, rdy, busy, interval_alarm_enable, day_alarm_enable, en};
      end
      `RTQ_OFF_TRIM:
      begin
        next_rdata = {elapsed, trim};
      end
      `RTQ_OFF_OSC:
      begin
        next_rdata = oscillator_control;
      end
      default:
      begin
        next_rdata = `RTQ_RST_ZERO;
      end
    endcase
  end

  // ==========================================
  // Registered outputs
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata <= `RTQ_RST_ZERO;
      calibration_output_pin <= 1'b0;
      clock_irq <= 1'b0;
      wakeup_req <= 1'b0;
    end
    else
    begin
      rdata <= rd ? next_rdata : `RTQ_RST_ZERO;
      calibration_output_pin <= next_sqw;
      clock_irq <= (day_flag & day_alarm_enable) | (int_flag & interval_alarm_enable)
                   | (rdy & ready_interrupt_enable);
      wakeup_req <= int_flag;
    end
  end

endmodule

`default_nettype wire

/* pkg/rtcsq_consts.vh */
// Register map, field positions, reset values and timing constants of the clock block
`ifndef RTCSQ_CONSTS_VH
`define RTCSQ_CONSTS_VH

// ==========================================
// Register offsets (byte addresses)
`define RTQ_OFF_SEC 5'h00
`define RTQ_OFF_SSEC 5'h04
`define RTQ_OFF_TODA 5'h08
`define RTQ_OFF_SSECA 5'h0C
`define RTQ_OFF_CTRL 5'h10
`define RTQ_OFF_TRIM 5'h14
`define RTQ_OFF_OSC 5'h18

// ==========================================
// Control register fields
`define RTQ_B_EN 0
`define RTQ_B_TOD_IE 1
`define RTQ_B_INT_IE 2
`define RTQ_B_BUSY 3
`define RTQ_B_RDY 4
`define RTQ_B_READY_INTERRUPT_ENABLE 5
`define RTQ_B_TOD_FL 6
`define RTQ_B_INT_FL 7
`define RTQ_B_SQW_EN 8
`define RTQ_B_SEL_LO 9
`define RTQ_B_SEL_HI 10
`define RTQ_B_RD_EN 14
`define RTQ_B_WR_EN 15

// Oscillator control: raw output bit
`define RTQ_B_RAW 5

// Square-wave select codes
`define RTQ_SEL_1HZ 2'h0
`define RTQ_SEL_512HZ 2'h1
`define RTQ_SEL_4KHZ 2'h2

// ==========================================
// Reset values
`define RTQ_RST_OSC 32'h0000_0009
`define RTQ_RST_ZERO 32'h0000_0000

// ==========================================
// Trim phase accumulator: one 32k edge is 1e6 units, one 4096 Hz tick is 8e6
`define RTQ_PH_STEP 24'h0F_4240
`define RTQ_PH_PERIOD 24'h7A_1200

// Sub-second wrap value and elapsed-counter period mask (32 s)
`define RTQ_SSEC_MAX 12'hFFF
`define RTQ_ELAPSE_MASK 5'h1F

// ==========================================
// Timing
`define RTQ_CLK_NS 25
`define RTQ_READY_NS 120000

`endif

/* verif/rtcsq_regs_chk.sv */
// Port checker for the clock register bank
`timescale 1ns/1ps
`default_nettype none
`include "rtcsq_consts.vh"
module rtcsq_regs_chk (
  input wire sys_clk,
  input wire nrst,
  input wire periph_rst,
  input wire oscillator_input_pin,
  input wire [4:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire calibration_output_pin,
  input wire clock_irq,
  input wire wakeup_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // Read port and reset
  chk_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero outside an answer");
  chk_unmapped_zero: assert property (rd && addr > `RTQ_OFF_OSC |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_reset_quiet: assert property ($rose(nrst) |-> rdata == 32'h0 && !clock_irq && !wakeup_req)
    else $error("outputs not quiet after reset");
  chk_ssec_reserved: assert property (rd && addr == `RTQ_OFF_SSEC |=> rdata[31:12] == 20'h0_0000)
    else $error("subsecond upper bits set");
  chk_toda_reserved: assert property (rd && addr == `RTQ_OFF_TODA |=> rdata[31:20] == 12'h000)
    else $error("day alarm upper bits set");
  // ==========================================
  // Sync handshake and status outputs
  // Busy must already show on the read right behind a staged write
  chk_busy_write: assert property (wr && addr == `RTQ_OFF_CTRL ##1 rd && addr == `RTQ_OFF_CTRL
    |=> rdata[`RTQ_B_BUSY])
    else $error("busy not set behind a control write");
  chk_wake_flag: assert property (rd && addr == `RTQ_OFF_CTRL |=> rdata[`RTQ_B_INT_FL] == wakeup_req)
    else $error("wake request differs from interval flag");
  chk_irq_combine: assert property (rd && addr == `RTQ_OFF_CTRL |=> clock_irq ==
    ((rdata[6] & rdata[1]) | (rdata[7] & rdata[2]) | (rdata[4] & rdata[5])))
    else $error("interrupt differs from gated flags");
  cover property (wakeup_req);
  cover property (clock_irq);
  cover property ($rose(calibration_output_pin));
endmodule
bind rtcsq_regs rtcsq_regs_chk rtcsq_regs_chk_i (.sys_clk(sys_clk), .nrst(nrst), .periph_rst(periph_rst),
  .oscillator_input_pin(oscillator_input_pin), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .calibration_output_pin(calibration_output_pin), .clock_irq(clock_irq), .wakeup_req(wakeup_req));
`default_nettype wire

/* verif/rtcsq_regs_tb.sv */
// Self-checking testbench for the clock register bank
`timescale 1ns/1ps
`default_nettype none
`include "rtcsq_consts.vh"
module rtcsq_regs_tb;
  localparam [4:0] a_c = `RTQ_OFF_CTRL;
  localparam [31:0] m = 32'hFFFF_FFE7;
  localparam [31:0] f = 32'hFFFF_FFFF;
  reg sys_clk = 1'b0;
  reg nrst = 1'b0;
  reg periph_rst = 1'b0;
  reg osc = 1'b0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [4:0] addr = 5'h00;
  reg [31:0] wdata = 32'h0;
  reg [4:0] ra;
  reg [31:0] d;
  reg [31:0] s;
  wire [31:0] rdata;
  wire cal_pin;
  wire clock_irq;
  wire wakeup_req;
  integer hi;
  integer lo;
  integer err_count = 0;
  integer num_checks = 0;
  // ==========================================
  // Clocks and design
  always #12.5 sys_clk = ~sys_clk;
  // Time base far faster than 32k to keep the run short: 16 bus cycles a period
  always #200 osc = ~osc;
  rtcsq_regs #(.READY_CYCLES(20)) rtcsq_regs_i (.sys_clk(sys_clk), .nrst(nrst), .periph_rst(periph_rst),
    .oscillator_input_pin(osc), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .calibration_output_pin(cal_pin), .clock_irq(clock_irq), .wakeup_req(wakeup_req));
  // ==========================================
  // Bus and compare tasks
  task chk(input [47:0] name, input [31:0] exp, input [31:0] got);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("Error %0s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task wreg(input [4:0] a, input [31:0] v);
  begin
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk);
    wr <= 1'b0;
  end
  endtask
  // Entered right after an edge; read data sits one cycle behind the strobe
  task rreg(input [4:0] a);
  begin
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    d = rdata;
  end
  endtask
  task wait_for(input [47:0] name, input [4:0] a, input [31:0] k, input [31:0] e);
    integer n;
  begin
    n = 0;
    rreg(a);
    while ((d & k) !== e && n < 300)
    begin
      rreg(a);
      n = n + 1;
    end
    chk(name, e, d & k);
  end
  endtask
  task wb(input [4:0] a, input [31:0] v);
  begin
    wreg(a, v);
    wait_for("busy", a_c, 32'h8, 32'h0);
  end
  endtask
  task rchk(input [47:0] name, input [4:0] a, input [31:0] k, input [31:0] e);
  begin
    rreg(a);
    chk(name, e, d & k);
  end
  endtask
  task lvl(input v, output integer n);
  begin
    n = 0;
    while (cal_pin === v && n < 1200)
    begin
      @(posedge sys_clk);
      n = n + 1;
    end
  end
  endtask
  // Skips the partial phase, then times one full high and low
  task sq(input [31:0] c, input [31:0] eh);
  begin
    wb(a_c, c);
    lvl(1'b1, hi);
    lvl(1'b0, lo);
    hi = 0;
    if (lo < 1200)
    begin
      lvl(1'b1, hi);
      lvl(1'b0, lo);
    end
    chk("hi", eh, hi);
    if (eh != 0)
      chk("lo", eh, lo);
  end
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
  begin
    rchk("osc", `RTQ_OFF_OSC, f, `RTQ_RST_OSC);
    for (ra = 5'h00; ra <= 5'h14; ra = ra + 5'h04)
      rchk("zero", ra, m, 32'h0);
    rchk("unmap", 5'h1C, f, 32'h0);
  end
  endtask
  task t_guard;
  begin
    wb(`RTQ_OFF_TRIM, 32'h0000_0055);
    rchk("trim", `RTQ_OFF_TRIM, f, 32'h0);
    wb(a_c, 32'h0000_0001);
    rchk("ctrl", a_c, m, 32'h0);
    @(posedge osc);
    wreg(a_c, 32'h0000_8000);
    rchk("busy", a_c, 32'h8, 32'h8);
    wait_for("busy", a_c, 32'h8, 32'h0);
    wb(a_c, 32'h0000_8001);
    rchk("ctrl", a_c, m, 32'h0000_8001);
    wb(`RTQ_OFF_TRIM, 32'h0000_0081);
    rchk("trim", `RTQ_OFF_TRIM, 32'hFF, 32'h81);
    wb(`RTQ_OFF_TRIM, 32'h0);
    // A second write while the first is in flight must be dropped
    @(posedge osc);
    wreg(a_c, 32'h0000_8101);
    wb(a_c, 32'h0000_8003);
    rchk("ctrl", a_c, m, 32'h0000_8101);
  end
  endtask
  task t_count;
  begin
    wb(`RTQ_OFF_SEC, 32'h0000_001F);
    wb(`RTQ_OFF_SSEC, 32'h0000_0FFE);
    wait_for("sec", `RTQ_OFF_SEC, f, 32'h20);
    rchk("elapse", `RTQ_OFF_TRIM, 32'hFFFF_FF00, 32'h100);
    wait_for("ready", a_c, 32'h10, 32'h10);
    wb(a_c, 32'h0000_8100);
    rreg(`RTQ_OFF_SSEC);
    s = d;
    repeat (100) rreg(`RTQ_OFF_SEC);
    rchk("ssec", `RTQ_OFF_SSEC, f, s);
  end
  endtask
  task t_square;
  begin
    sq(32'h0000_8100, 32'h0);
    sq(32'h0000_8500, 32'h40);
    sq(32'h0000_8301, 32'h200);
    sq(32'h0000_8701, 32'h0);
    sq(32'h0000_8400, 32'h0);
    wb(`RTQ_OFF_OSC, 32'h0000_0029);
    lvl(1'b1, hi);
    lvl(1'b0, lo);
    lvl(1'b1, hi);
    chk("raw", 32'h8, hi);
    wb(`RTQ_OFF_OSC, `RTQ_RST_OSC);
  end
  endtask
  task t_alarm;
  begin
    wb(a_c, 32'h0000_8001);
    wb(`RTQ_OFF_TODA, 32'h40);
    wb(a_c, 32'h0000_8003);
    wb(`RTQ_OFF_TODA, 32'h55);
    rchk("toda", `RTQ_OFF_TODA, f, 32'h40);
    wb(`RTQ_OFF_SEC, 32'h40);
    wait_for("dayfl", a_c, 32'h40, 32'h40);
    chk("irq", 32'h1, {31'h0, clock_irq});
    wb(a_c, 32'h0000_8041);
    chk("irq", 32'h0, {31'h0, clock_irq});
    wb(`RTQ_OFF_SSECA, 32'hFFFF_FFFE);
    wb(a_c, 32'h0000_8005);
    wait_for("intfl", a_c, 32'h80, 32'h80);
    chk("wake", 32'h1, {31'h0, wakeup_req});
    wb(`RTQ_OFF_SSECA, 32'h5);
    rchk("sseca", `RTQ_OFF_SSECA, f, 32'hFFFF_FFFE);
  end
  endtask
  task t_prst;
  begin
    wb(a_c, 32'h0000_8025);
    @(posedge sys_clk);
    periph_rst <= 1'b1;
    @(posedge sys_clk);
    periph_rst <= 1'b0;
    rchk("ctrl", a_c, 32'h0000_8027, 32'h5);
    wb(`RTQ_OFF_OSC, 32'h0000_0029);
    rchk("osc", `RTQ_OFF_OSC, f, `RTQ_RST_OSC);
  end
  endtask
  // Calibration order: clear ready, wait ready, busy, write-enable, trim, busy, clear
  task t_cal;
  begin
    wb(a_c, 32'h0000_0001);
    wait_for("ready", a_c, 32'h10, 32'h10);
    wait_for("busy", a_c, 32'h8, 32'h0);
    wb(a_c, 32'h0000_8001);
    wb(`RTQ_OFF_TRIM, 32'h0000_007F);
    wb(a_c, 32'h0000_0001);
    rchk("trim", `RTQ_OFF_TRIM, 32'hFF, 32'h7F);
    rchk("wren", a_c, 32'h8000, 32'h0);
  end
  endtask
  // Asynchronous reads are repeated until two in a row agree
  task t_async;
    integer n;
  begin
    n = 0;
    wb(a_c, 32'h0000_C001);
    rchk("rden", a_c, 32'h4000, 32'h4000);
    rreg(`RTQ_OFF_SSEC);
    s = d;
    rreg(`RTQ_OFF_SSEC);
    while (d !== s && n < 20)
    begin
      s = d;
      rreg(`RTQ_OFF_SSEC);
      n = n + 1;
    end
    chk("async", s, d);
  end
  endtask
  task results;
  begin
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // ==========================================
  // Sequence and watchdog
  initial
  begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset;
    t_guard;
    t_count;
    t_square;
    t_alarm;
    t_prst;
    t_cal;
    t_async;
    results;
  end
  initial
  begin
    #(25 * 80000);
    err_count = err_count + 1;
    results;
  end
endmodule
`default_nettype wire
